// >>> core/ufci_pkg.sv
// Shared constants for the UART FIFO control and interrupt status block
package ufci_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the plain register port
	// ----------------------------------------------------------------
	localparam logic [2:0] UFCI_OFS_DATA = 3'h0;      // Write: tx holding, read: rx data
	localparam logic [2:0] UFCI_OFS_SETUP = 3'h2;     // Write: fifo_setup, read: interrupt_source_id
	localparam logic [2:0] UFCI_OFS_SETUP_RB = 3'h3;  // Read back of fifo_setup
	localparam logic [2:0] UFCI_OFS_TX_LEVEL = 3'h4;  // Transmit FIFO fill count
	localparam logic [2:0] UFCI_OFS_RX_LEVEL = 3'h5;  // Receive FIFO fill count

	// ----------------------------------------------------------------
	// fifo_setup field positions and reset value
	// ----------------------------------------------------------------
	localparam int UFCI_FS_EN = 0;          // FIFO enable
	localparam int UFCI_FS_RX_RST = 1;      // Receive FIFO reset, self clearing
	localparam int UFCI_FS_TX_RST = 2;      // Transmit FIFO reset, self clearing
	localparam int UFCI_FS_DMA = 3;         // DMA signalling mode
	localparam int UFCI_FS_TX_TRG = 4;      // Transmit trigger field, two bits
	localparam int UFCI_FS_RX_TRG = 6;      // Receive trigger field, two bits
	localparam logic [7:0] UFCI_SETUP_RST = 8'h00;
	localparam logic [7:0] UFCI_ISR_RST = 8'h01;

	// ----------------------------------------------------------------
	// Interrupt source codes, bits five to zero
	// ----------------------------------------------------------------
	localparam logic [5:0] UFCI_CODE_LINE = 6'h06;    // Level 1
	localparam logic [5:0] UFCI_CODE_RXDATA = 6'h04;  // Level 2
	localparam logic [5:0] UFCI_CODE_RXTO = 6'h0c;    // Level 2
	localparam logic [5:0] UFCI_CODE_TXEMPTY = 6'h02; // Level 3
	localparam logic [5:0] UFCI_CODE_MODEM = 6'h00;   // Level 4
	localparam logic [5:0] UFCI_CODE_XOFF = 6'h10;    // Level 5
	localparam logic [5:0] UFCI_CODE_FLOW = 6'h20;    // Level 6
	localparam logic [5:0] UFCI_CODE_NONE = 6'h01;    // Nothing pending

	// ----------------------------------------------------------------
	// Trigger thresholds in bytes
	// ----------------------------------------------------------------
	localparam logic [5:0] UFCI_RX_TRIG_0 = 6'h08;
	localparam logic [5:0] UFCI_RX_TRIG_1 = 6'h10;
	localparam logic [5:0] UFCI_RX_TRIG_2 = 6'h18;
	localparam logic [5:0] UFCI_RX_TRIG_3 = 6'h1c;
	localparam logic [5:0] UFCI_TX_TRIG_0 = 6'h10;
	localparam logic [5:0] UFCI_TX_TRIG_1 = 6'h08;
	localparam logic [5:0] UFCI_TX_TRIG_2 = 6'h18;
	localparam logic [5:0] UFCI_TX_TRIG_3 = 6'h1e;
	localparam int UFCI_FIFO_DEPTH = 32;

	// Block mode receive request state
	typedef enum logic [0:0] {
		UFCI_REQ_IDLE = 1'b0,
		UFCI_REQ_ACTIVE = 1'b1
	} ufci_req_e;

endpackage : ufci_pkg

// >>> core/ufci_core.sv
// FIFO control, DMA request pins and prioritised interrupt status of a UART
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module ufci_core #(
	parameter int FIFO_DEPTH = ufci_pkg::UFCI_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Transmit shift register side
	input wire logic tx_pop,
	output logic [7:0] tx_data,
	output logic tx_valid,
	// Receive shift register side
	input wire logic rx_push,
	input wire logic [7:0] rx_byte,
	// Event inputs from neighbouring logic
	input wire logic line_status_event,
	input wire logic rx_timeout_event,
	input wire logic modem_status_event,
	input wire logic xoff_detect,
	input wire logic xon_detect,
	input wire logic flow_change_event,
	input wire logic enhanced_feature_reg4,
	// DMA request pins and interrupt summary
	output logic tx_dma_request_n,
	output logic rx_dma_request_n,
	output logic int_pending
);
	import ufci_pkg::*;

	// ----------------------------------------------------------------
	// Local widths
	// ----------------------------------------------------------------
	localparam int AW = $clog2(FIFO_DEPTH);   // Pointer width
	localparam int CW = AW + 1;                // Count width, holds full depth
	localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);
	localparam logic [CW-1:0] ONE_CNT = CW'(1);

	// Receive trigger decode
	function automatic logic [CW-1:0] rx_trig_f(input logic [1:0] sel);
		case (sel)
			2'h0: rx_trig_f = CW'(UFCI_RX_TRIG_0);
			2'h1: rx_trig_f = CW'(UFCI_RX_TRIG_1);
			2'h2: rx_trig_f = CW'(UFCI_RX_TRIG_2);
			default: rx_trig_f = CW'(UFCI_RX_TRIG_3);
		endcase
	endfunction : rx_trig_f

	// Transmit trigger decode
	function automatic logic [CW-1:0] tx_trig_f(input logic [1:0] sel);
		case (sel)
			2'h0: tx_trig_f = CW'(UFCI_TX_TRIG_0);
			2'h1: tx_trig_f = CW'(UFCI_TX_TRIG_1);
			2'h2: tx_trig_f = CW'(UFCI_TX_TRIG_2);
			default: tx_trig_f = CW'(UFCI_TX_TRIG_3);
		endcase
	endfunction : tx_trig_f

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic fifo_en_r;             // FIFO enable
	logic dma_mode_r;            // Block mode select
	logic [1:0] tx_trg_r;        // Transmit trigger code
	logic [1:0] rx_trg_r;        // Receive trigger code
	logic wr_setup;              // Write to fifo_setup
	logic rd_status;             // Read of interrupt_source_id
	logic tx_clr;                // Transmit FIFO flush
	logic rx_clr;                // Receive FIFO flush
	logic block_mode;            // FIFOs on and block mode
	logic [CW-1:0] cap;          // Usable FIFO capacity
	logic [CW-1:0] tx_trig;      // Decoded transmit threshold
	logic [CW-1:0] rx_trig;      // Decoded receive threshold
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [AW-1:0] tx_wr_ptr_r;
	logic [AW-1:0] tx_rd_ptr_r;
	logic [CW-1:0] tx_cnt_r;
	logic [CW-1:0] tx_cnt_nxt;
	logic [AW-1:0] tx_rd_nxt;
	logic tx_push;               // Host byte accepted
	logic tx_pop_ok;             // Shift register took a byte
	logic [7:0] rx_mem [FIFO_DEPTH];
	logic [AW-1:0] rx_wr_ptr_r;
	logic [AW-1:0] rx_rd_ptr_r;
	logic [CW-1:0] rx_cnt_r;
	logic rx_push_ok;            // Received byte stored
	logic rx_pop_ok;             // Host read a byte
	logic line_p_r;              // Pending: line status
	logic rxto_p_r;              // Pending: receive timeout
	logic txe_p_r;               // Pending: transmit below trigger
	logic modem_p_r;             // Pending: modem status
	logic xoff_p_r;              // Pending: Xoff or special character
	logic flow_p_r;              // Pending: flow line change
	logic rx_data_lvl;           // Receive data at threshold
	logic tx_low;                // Transmit fill below threshold
	logic tx_low_d_r;            // Previous tx_low for edge
	logic [5:0] isr_code;        // Live highest source code
	ufci_req_e rx_req_r;         // Block mode receive state
	ufci_req_e rx_req_nxt;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	assign wr_setup = reg_wr && (reg_addr == UFCI_OFS_SETUP);
	assign rd_status = reg_rd && (reg_addr == UFCI_OFS_SETUP);
	// Flush on reset bit written with enable set, or when the enable bit changes
	assign tx_clr = wr_setup && ((reg_wdata[UFCI_FS_EN] && reg_wdata[UFCI_FS_TX_RST]) ||
		(reg_wdata[UFCI_FS_EN] != fifo_en_r));
	assign rx_clr = wr_setup && ((reg_wdata[UFCI_FS_EN] && reg_wdata[UFCI_FS_RX_RST]) ||
		(reg_wdata[UFCI_FS_EN] != fifo_en_r));
	assign block_mode = fifo_en_r && dma_mode_r;
	// Without FIFOs each side holds one byte
	assign cap = fifo_en_r ? FULL_CNT : ONE_CNT;
	assign tx_trig = tx_trig_f(tx_trg_r);
	assign rx_trig = rx_trig_f(rx_trg_r);

	// ----------------------------------------------------------------
	// fifo_setup register
	// ----------------------------------------------------------------
	// Reset bits are pulses only and never stored
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fifo_en_r <= UFCI_SETUP_RST[UFCI_FS_EN];
			dma_mode_r <= UFCI_SETUP_RST[UFCI_FS_DMA];
			tx_trg_r <= UFCI_SETUP_RST[UFCI_FS_TX_TRG +: 2];
			rx_trg_r <= UFCI_SETUP_RST[UFCI_FS_RX_TRG +: 2];
		end else if (wr_setup) begin
			fifo_en_r <= reg_wdata[UFCI_FS_EN];
			// Other fields only taken with enable set
			if (reg_wdata[UFCI_FS_EN]) begin
				dma_mode_r <= reg_wdata[UFCI_FS_DMA];
				tx_trg_r <= reg_wdata[UFCI_FS_TX_TRG +: 2];
				rx_trg_r <= reg_wdata[UFCI_FS_RX_TRG +: 2];
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit FIFO
	// ----------------------------------------------------------------
	assign tx_push = reg_wr && (reg_addr == UFCI_OFS_DATA) && (tx_cnt_r < cap);
	assign tx_pop_ok = tx_pop && (tx_cnt_r != '0);
	assign tx_rd_nxt = tx_rd_ptr_r + AW'(tx_pop_ok);

	// Next fill count, flush wins
	always_comb begin
		if (tx_clr) begin
			tx_cnt_nxt = '0;
		end else begin
			tx_cnt_nxt = tx_cnt_r + CW'(tx_push) - CW'(tx_pop_ok);
		end
	end

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (tx_push) begin
			tx_mem[tx_wr_ptr_r] <= reg_wdata;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_sys) begin
		if (sys_rst || tx_clr) begin
			tx_wr_ptr_r <= '0;
			tx_rd_ptr_r <= '0;
			tx_cnt_r <= '0;
		end else begin
			tx_wr_ptr_r <= tx_wr_ptr_r + AW'(tx_push);
			tx_rd_ptr_r <= tx_rd_nxt;
			tx_cnt_r <= tx_cnt_nxt;
		end
	end

	// Head byte offered to the shift register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
		end else begin
			tx_valid <= (tx_cnt_nxt != '0);
			// Bypass when the FIFO would otherwise be empty
			if (tx_cnt_r == CW'(tx_pop_ok)) begin
				tx_data <= reg_wdata;
			end else begin
				tx_data <= tx_mem[tx_rd_nxt];
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive FIFO
	// ----------------------------------------------------------------
	assign rx_push_ok = rx_push && (rx_cnt_r < cap);
	assign rx_pop_ok = reg_rd && (reg_addr == UFCI_OFS_DATA) && (rx_cnt_r != '0);

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (rx_push_ok) begin
			rx_mem[rx_wr_ptr_r] <= rx_byte;
		end
	end

	// Pointers and count, shift register untouched by flush
	always_ff @(posedge clk_sys) begin
		if (sys_rst || rx_clr) begin
			rx_wr_ptr_r <= '0;
			rx_rd_ptr_r <= '0;
			rx_cnt_r <= '0;
		end else begin
			rx_wr_ptr_r <= rx_wr_ptr_r + AW'(rx_push_ok);
			rx_rd_ptr_r <= rx_rd_ptr_r + AW'(rx_pop_ok);
			rx_cnt_r <= rx_cnt_r + CW'(rx_push_ok) - CW'(rx_pop_ok);
		end
	end

	// ----------------------------------------------------------------
	// Interrupt sources
	// ----------------------------------------------------------------
	assign rx_data_lvl = fifo_en_r ? (rx_cnt_r >= rx_trig) : (rx_cnt_r != '0);
	assign tx_low = fifo_en_r ? (tx_cnt_r < tx_trig) : (tx_cnt_r == '0);

	// Edge memory for the transmit threshold
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_low_d_r <= 1'b0;
		end else begin
			tx_low_d_r <= tx_low;
		end
	end

	// Priority encoder, evaluated every cycle; only the winner is shown
	always_comb begin
		if (line_p_r) begin
			isr_code = UFCI_CODE_LINE;
		end else if (rx_data_lvl) begin
			isr_code = UFCI_CODE_RXDATA;
		end else if (rxto_p_r) begin
			isr_code = UFCI_CODE_RXTO;
		end else if (txe_p_r) begin
			isr_code = UFCI_CODE_TXEMPTY;
		end else if (modem_p_r) begin
			isr_code = UFCI_CODE_MODEM;
		end else if (xoff_p_r && enhanced_feature_reg4) begin
			isr_code = UFCI_CODE_XOFF;
		end else if (flow_p_r && enhanced_feature_reg4) begin
			isr_code = UFCI_CODE_FLOW;
		end else begin
			isr_code = UFCI_CODE_NONE;
		end
	end

	// Sticky sources: set wins, status read clears only the code it returned
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			line_p_r <= 1'b0;
			rxto_p_r <= 1'b0;
			txe_p_r <= 1'b0;
			modem_p_r <= 1'b0;
			flow_p_r <= 1'b0;
		end else begin
			if (line_status_event) begin
				line_p_r <= 1'b1;
			end else if (rd_status && isr_code == UFCI_CODE_LINE) begin
				line_p_r <= 1'b0;
			end
			if (rx_timeout_event) begin
				rxto_p_r <= 1'b1;
			end else if (rx_pop_ok || (rd_status && isr_code == UFCI_CODE_RXTO)) begin
				rxto_p_r <= 1'b0;
			end
			if (tx_low && !tx_low_d_r) begin
				txe_p_r <= 1'b1;
			end else if (tx_push || (rd_status && isr_code == UFCI_CODE_TXEMPTY)) begin
				txe_p_r <= 1'b0;
			end
			if (modem_status_event) begin
				modem_p_r <= 1'b1;
			end else if (rd_status && isr_code == UFCI_CODE_MODEM) begin
				modem_p_r <= 1'b0;
			end
			if (flow_change_event && enhanced_feature_reg4) begin
				flow_p_r <= 1'b1;
			end else if (rd_status && isr_code == UFCI_CODE_FLOW) begin
				flow_p_r <= 1'b0;
			end
		end
	end

	// Xoff status ignores reads, only Xon ends it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			xoff_p_r <= 1'b0;
		end else if (xoff_detect && enhanced_feature_reg4) begin
			xoff_p_r <= 1'b1;
		end else if (xon_detect) begin
			xoff_p_r <= 1'b0;
		end
	end

	// Interrupt summary
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			int_pending <= 1'b0;
		end else begin
			int_pending <= (isr_code != UFCI_CODE_NONE);
		end
	end

	// ----------------------------------------------------------------
	// DMA request pins
	// ----------------------------------------------------------------
	// Transmit request: hysteresis in block mode, empty test otherwise
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_dma_request_n <= 1'b0;
		end else if (block_mode) begin
			if (tx_cnt_r >= FULL_CNT) begin
				tx_dma_request_n <= 1'b1;
			end else if (tx_cnt_r <= tx_trig) begin
				tx_dma_request_n <= 1'b0;
			end
		end else begin
			tx_dma_request_n <= (tx_cnt_r != '0);
		end
	end

	// Receive request state
	always_comb begin
		case (rx_req_r)
			UFCI_REQ_IDLE: begin
				if (block_mode && (rx_cnt_r >= rx_trig || rx_timeout_event)) begin
					rx_req_nxt = UFCI_REQ_ACTIVE;
				end else begin
					rx_req_nxt = UFCI_REQ_IDLE;
				end
			end
			UFCI_REQ_ACTIVE: begin
				if (!block_mode || rx_cnt_r == '0) begin
					rx_req_nxt = UFCI_REQ_IDLE;
				end else begin
					rx_req_nxt = UFCI_REQ_ACTIVE;
				end
			end
			default: rx_req_nxt = UFCI_REQ_IDLE;
		endcase
	end

	// Receive request pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_req_r <= UFCI_REQ_IDLE;
			rx_dma_request_n <= 1'b1;
		end else begin
			rx_req_r <= rx_req_nxt;
			if (block_mode) begin
				rx_dma_request_n <= (rx_req_nxt != UFCI_REQ_ACTIVE);
			end else begin
				rx_dma_request_n <= (rx_cnt_r == '0);
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data, valid only in the cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				UFCI_OFS_DATA: reg_rdata <= (rx_cnt_r != '0) ? rx_mem[rx_rd_ptr_r] : 8'h00;
				// Code captured at the strobe
				UFCI_OFS_SETUP: reg_rdata <= {fifo_en_r, fifo_en_r, isr_code};
				UFCI_OFS_SETUP_RB: reg_rdata <= {rx_trg_r, tx_trg_r, dma_mode_r, 2'b00, fifo_en_r};
				UFCI_OFS_TX_LEVEL: reg_rdata <= 8'(tx_cnt_r);
				UFCI_OFS_RX_LEVEL: reg_rdata <= 8'(rx_cnt_r);
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule : ufci_core

// >>> test/ufci_checker.sv
// Port-level assertions for the FIFO control and interrupt status block
`timescale 1ns/1ps
module ufci_checker #(
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Stream sides
	input wire logic tx_pop,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic rx_push,
	input wire logic [7:0] rx_byte,
	// Events
	input wire logic line_status_event,
	input wire logic rx_timeout_event,
	input wire logic modem_status_event,
	input wire logic xoff_detect,
	input wire logic xon_detect,
	input wire logic flow_change_event,
	input wire logic enhanced_feature_reg4,
	// Pins
	input wire logic tx_dma_request_n,
	input wire logic rx_dma_request_n,
	input wire logic int_pending
);
	import ufci_pkg::*;
	// ----------------------------------------
	// Helper: no drain, register write or timeout
	// ----------------------------------------
	logic [1:0] quiet_r; // Two-cycle history, pin lags the count
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			quiet_r <= 2'b00;
		end else begin
			quiet_r <= {quiet_r[0], !reg_wr && !rx_timeout_event && !(reg_rd && reg_addr == UFCI_OFS_DATA)};
		end
	end
	default clocking ufci_cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_rd_idle; // Read data zero outside the answer cycle
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
	property p_tx_push; // Push into empty FIFO shows at head
		reg_wr && reg_addr == UFCI_OFS_DATA && !tx_valid |=> tx_valid && tx_data == $past(reg_wdata);
	endproperty
	a_tx_push: assert property (p_tx_push) else $error("pushed byte not at tx head");
	property p_isr_form; // Bits 7 and 6 agree, idle code has no source bits
		reg_rd && reg_addr == UFCI_OFS_SETUP |=> reg_rdata[7] == reg_rdata[6] && (!reg_rdata[0] || reg_rdata[5:1] == 5'h00);
	endproperty
	a_isr_form: assert property (p_isr_form) else $error("status value malformed");
	property p_int_pend; // Summary pin agrees with status bit zero
		reg_rd && reg_addr == UFCI_OFS_SETUP |=> int_pending == !reg_rdata[0];
	endproperty
	a_int_pend: assert property (p_int_pend) else $error("pending pin disagrees with status");
	property p_ext_gate; // Levels five and six hidden without enhanced bit
		reg_rd && reg_addr == UFCI_OFS_SETUP && !enhanced_feature_reg4 |=> reg_rdata[5:4] == 2'b00;
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("gated status bits set");
	property p_line_prio; // Line status wins over all others
		line_status_event ##1 !reg_rd ##1 (reg_rd && reg_addr == UFCI_OFS_SETUP) |=> reg_rdata[5:0] == UFCI_CODE_LINE;
	endproperty
	a_line_prio: assert property (p_line_prio) else $error("line status not reported first");
	property p_line_clear; // Reported source gone on the next read
		(reg_rd && reg_addr == UFCI_OFS_SETUP && !line_status_event) ##1
		(reg_rdata[5:0] == UFCI_CODE_LINE && !line_status_event) ##1
		(reg_rd && reg_addr == UFCI_OFS_SETUP && !line_status_event) |=> reg_rdata[5:0] != UFCI_CODE_LINE;
	endproperty
	a_line_clear: assert property (p_line_clear) else $error("reported source not cleared");
	property p_rx_hold; // Receive request holds low while nothing drains
		!rx_dma_request_n && quiet_r == 2'b11 |=> !rx_dma_request_n;
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("receive request released early");
	// Main scenarios reached
	c_tx_full: cover property (!tx_dma_request_n ##1 tx_dma_request_n);
	c_rx_req: cover property (rx_dma_request_n ##1 !rx_dma_request_n);
	c_flow: cover property (reg_rd ##1 reg_rdata[5:0] == UFCI_CODE_FLOW);
endmodule : ufci_checker
bind ufci_core ufci_checker #(.FIFO_DEPTH(FIFO_DEPTH)) ufci_checker_inst (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .tx_pop, .tx_data, .tx_valid, .rx_push, .rx_byte, .line_status_event,
	.rx_timeout_event, .modem_status_event, .xoff_detect, .xon_detect, .flow_change_event, .enhanced_feature_reg4,
	.tx_dma_request_n, .rx_dma_request_n, .int_pending);

// >>> test/ufci_tx_drain.sv
// Transmit shift register stand-in that takes bytes from the tx FIFO
`timescale 1ns/1ps
module ufci_tx_drain (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Pacing, low stalls
	input wire logic drain_en,
	// FIFO head
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_pop,
	output logic [7:0] last_byte
);
	// One pop per paced cycle, changed right after the edge
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_pop <= 1'b0;
		end else begin
			tx_pop <= drain_en;
		end
	end
	// Byte taken at the pop edge
	always_ff @(posedge clk_sys) begin
		if (tx_pop && tx_valid) begin
			last_byte <= tx_data;
		end
	end
endmodule : ufci_tx_drain

// >>> test/tb_uart_fifo_ctrl_irq_status.sv
// Self-checking testbench for the FIFO control and interrupt status block
`timescale 1ns/1ps
module tb_uart_fifo_ctrl_irq_status;
	import ufci_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys = 1'b0, sys_rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, rx_byte = 8'h00, reg_rdata, tx_data, last_byte;
	logic reg_wr = 1'b0, reg_rd = 1'b0, rx_push = 1'b0, enh = 1'b0, drain_en = 1'b0;
	logic tx_pop, tx_valid, tx_dma_request_n, rx_dma_request_n;
	logic [5:0] ev = 6'h00; // Line, timeout, modem, xoff, xon, flow
	int n_errors = 0, compares = 0;
	ufci_core #(.FIFO_DEPTH(32)) ufci_core_inst (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .tx_pop, .tx_data, .tx_valid, .rx_push, .rx_byte, .line_status_event(ev[5]),
		.rx_timeout_event(ev[4]), .modem_status_event(ev[3]), .xoff_detect(ev[2]), .xon_detect(ev[1]),
		.flow_change_event(ev[0]), .enhanced_feature_reg4(enh), .tx_dma_request_n, .rx_dma_request_n, .int_pending());
	ufci_tx_drain ufci_tx_drain_inst (.clk_sys, .sys_rst, .drain_en, .tx_valid, .tx_data, .tx_pop, .last_byte);
	initial forever #50 clk_sys = ~clk_sys;
	// ----------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// Read, answer taken in the cycle after the strobe
	task automatic rc(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, exp);
	endtask : rc
	task automatic push_rx(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			rx_push <= 1'b1;
			rx_byte <= rx_byte + 8'h01;
		end
		@(posedge clk_sys);
		rx_push <= 1'b0;
	endtask : push_rx
	task automatic pulse(input logic [5:0] m);
		@(posedge clk_sys);
		ev <= m;
		@(posedge clk_sys);
		ev <= 6'h00;
	endtask : pulse
	task automatic drain(input int n);
		@(posedge clk_sys);
		drain_en <= 1'b1;
		repeat (n) @(posedge clk_sys);
		drain_en <= 1'b0;
	endtask : drain
	// Request pin three edges on, read once settled; rx_sel picks the receive pin
	task automatic pin(input logic rx_sel, input logic [7:0] exp);
		repeat (3) @(posedge clk_sys);
		#1 chk({7'h00, rx_sel ? rx_dma_request_n : tx_dma_request_n}, exp);
	endtask : pin
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		repeat (2) @(posedge clk_sys);
		rc(UFCI_OFS_SETUP, 8'h02, 8'hff);
		rc(UFCI_OFS_SETUP, 8'h01, 8'hff);
		rc(UFCI_OFS_SETUP_RB, 8'h00, 8'hff);
		rc(3'h7, 8'h00, 8'hff);
	endtask : t_reset
	task automatic t_setup();
		wr(UFCI_OFS_SETUP, 8'h38);
		rc(UFCI_OFS_SETUP_RB, 8'h00, 8'hff);
		wr(UFCI_OFS_SETUP, 8'hc9);
		rc(UFCI_OFS_SETUP_RB, 8'hc9, 8'hff);
		wr(UFCI_OFS_DATA, 8'h11);
		push_rx(2);
		rc(UFCI_OFS_RX_LEVEL, 8'h02, 8'hff);
		wr(UFCI_OFS_SETUP, 8'hcf);
		rc(UFCI_OFS_SETUP_RB, 8'hc9, 8'hff);
		rc(UFCI_OFS_TX_LEVEL, 8'h00, 8'hff);
		rc(UFCI_OFS_RX_LEVEL, 8'h00, 8'hff);
	endtask : t_setup
	task automatic t_rx_trig();
		logic [5:0] lv [4] = '{6'h08, 6'h10, 6'h18, 6'h1c};
		for (int k = 0; k < 4; k++) begin
			wr(UFCI_OFS_SETUP, {2'(k), 6'h01});
			push_rx(int'(lv[k]) - 1);
			rc(UFCI_OFS_SETUP, 8'h00, 8'h0c);
			push_rx(1);
			rc(UFCI_OFS_SETUP, 8'hc4, 8'hff);
			wr(UFCI_OFS_SETUP, {2'(k), 6'h03});
		end
	endtask : t_rx_trig
	task automatic t_tx_trig();
		logic [5:0] lv [4] = '{6'h10, 6'h08, 6'h18, 6'h1e};
		for (int k = 0; k < 4; k++) begin
			wr(UFCI_OFS_SETUP, {2'b00, 2'(k), 4'hd});
			for (int i = 0; i < 32; i++) begin
				wr(UFCI_OFS_DATA, 8'(i));
			end
			pin(1'b0, 8'h01);
			drain(32 - int'(lv[k]));
			pin(1'b0, 8'h00);
			drain(1);
			repeat (3) @(posedge clk_sys);
			rc(UFCI_OFS_SETUP, 8'hc2, 8'hff);
			chk(last_byte, 8'(32 - int'(lv[k])));
		end
	endtask : t_tx_trig
	task automatic t_rx_block();
		logic [7:0] b;
		wr(UFCI_OFS_SETUP, 8'h09);
		b = rx_byte;
		push_rx(7);
		pin(1'b1, 8'h01);
		push_rx(1);
		pin(1'b1, 8'h00);
		for (int i = 1; i < 8; i++) begin
			rc(UFCI_OFS_DATA, b + 8'(i), 8'hff);
		end
		pin(1'b1, 8'h00);
		rc(UFCI_OFS_DATA, b + 8'h08, 8'hff);
		pin(1'b1, 8'h01);
		push_rx(1);
		pulse(6'h10);
		pin(1'b1, 8'h00);
		rc(UFCI_OFS_SETUP, 8'hcc, 8'hff);
		rc(UFCI_OFS_DATA, b + 8'h09, 8'hff);
		pin(1'b1, 8'h01);
	endtask : t_rx_block
	task automatic t_prio();
		pulse(6'h05);
		rc(UFCI_OFS_SETUP, 8'hc1, 8'hff);
		@(posedge clk_sys);
		enh <= 1'b1;
		pulse(6'h2d);
		rc(UFCI_OFS_SETUP, 8'hc6, 8'hff);
		rc(UFCI_OFS_SETUP, 8'hc0, 8'hff);
		rc(UFCI_OFS_SETUP, 8'hd0, 8'hff);
		rc(UFCI_OFS_SETUP, 8'hd0, 8'hff);
		pulse(6'h02);
		rc(UFCI_OFS_SETUP, 8'he0, 8'hff);
		rc(UFCI_OFS_SETUP, 8'hc1, 8'hff);
	endtask : t_prio
	// ----------------------------------------
	// Verdict and sequence
	// ----------------------------------------
	task automatic stop_test();
		if (n_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_setup();
		t_rx_trig();
		t_tx_trig();
		t_rx_block();
		t_prio();
		stop_test();
	end
	// Watchdog, some thirty times the expected run of some six hundred cycles
	initial begin
		#2_000_000;
		n_errors++;
		stop_test();
	end
endmodule : tb_uart_fifo_ctrl_irq_status
